//--- design/irq_unit_pkg.sv
// Constants and types for the two-source interrupt unit
// Function
// - Starting any interrupt service clears the global enable.
// - Requests still set pending flags while the global enable is cleared.
// - Re-enabling global and source enable in a handler allows nesting.
// - No acknowledge while the return stack is full; wait for a return.
// - Acknowledge pushes only the program counter, then branches to vector.
// - Falling edge on the interrupt pin sets the external flag, bit 4.
// - External service calls 04H, clears its flag and the global enable.
// - Timer overflow sets the timer pending flag, bit 5.
// - Timer service calls 08H, clears its flag and the global enable.
// - Return-from-interrupt sets the global enable; plain return leaves it.
// - Requests between two phase-two pulses are serviced on the later pulse.
// - Simultaneous requests: external first, timer second.
// - Control bits: 0 global, 1 external, 2 timer enable; one enables.
// - Flags stay until serviced or cleared; service needs both enables.
// - Both sources can raise a wake-up out of power-down.
package irq_unit_pkg;
   localparam logic [5:0] CTRL_INDEX = 6'h0b;
   localparam logic [5:0] AXI_CTRL_ADDR = {CTRL_INDEX[3:0], 2'b00};
   localparam logic [5:0] AXI_STAT_ADDR = 6'h30;
   localparam logic [5:0] AXI_MASK_ADDR = 6'h34;
   localparam logic [5:0] AXI_STACK_ADDR = 6'h38;
   localparam int GIE_BIT = 0;
   localparam int EIE_BIT = 1;
   localparam int TIE_BIT = 2;
   localparam int EPEND_BIT = 4;
   localparam int TPEND_BIT = 5;
   localparam logic [7:0] CTRL_WMASK = 8'h37;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [9:0] EXT_VECTOR = 10'h004;
   localparam logic [9:0] TMR_VECTOR = 10'h008;
   localparam logic [1:0] STACK_DEPTH = 2'h2;
   localparam logic [1:0] AXI_OKAY = 2'h0;
   localparam logic [1:0] AXI_SLVERR = 2'h2;
   localparam logic [1:0] EVT_W = 2'h2;
   typedef struct packed
   {
      logic valid;
      logic [9:0] vector;
   } ack_t;
endpackage

//--- design/irq_unit.sv
// Two-source interrupt unit with AXI4-Lite register access
`timescale 1ns/1ps
module irq_unit
(
   input wire logic i_clk,
   input wire logic i_arst_n,
   input wire logic i_ext_irq_n,
   input wire logic i_timer_overflow,
   input wire logic i_phase_two_pulse,
   input wire logic i_return_from_irq_op,
   input wire logic i_plain_return_op,
   input wire logic i_call_op,
   input wire logic i_halted,
   input wire logic [5:0] i_awaddr,
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   input wire logic i_wvalid,
   output logic o_wready,
   output logic [1:0] o_bresp,
   output logic o_bvalid,
   input wire logic i_bready,
   input wire logic [5:0] i_araddr,
   input wire logic i_arvalid,
   output logic o_arready,
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp,
   output logic o_rvalid,
   input wire logic i_rready,
   output irq_unit_pkg::ack_t o_ack,
   output logic o_push_pc,
   output logic o_wake,
   output logic o_irq
);

////////////////////////////////////////////////////////////////////////////////
// Control register state and stack tracking
logic global_irq_enable;
logic ext_irq_enable;
logic timer_irq_enable;
logic ext_irq_pending;
logic timer_irq_pending;
logic [1:0] stack_level_index;
logic ext_pin_q;
logic ext_fall;
logic stack_full;
logic req_ext;
logic req_tmr;
logic service;
logic take_ext;
logic take_tmr;
logic [7:0] interrupt_control;
logic [1:0] evt_status;
logic [1:0] evt_mask;

// AXI write path
logic aw_held;
logic w_held;
logic [5:0] aw_addr;
logic [31:0] w_data;
logic [3:0] w_strb;
logic wr_go;
logic ctrl_wr;
logic [7:0] wr_byte;
logic [5:0] wr_addr;
logic wr_lane0;
logic stat_clr;

assign stack_full = (stack_level_index == irq_unit_pkg::STACK_DEPTH);
assign ext_fall = ext_pin_q & ~i_ext_irq_n;
assign req_ext = ext_irq_pending & ext_irq_enable;
assign req_tmr = timer_irq_pending & timer_irq_enable;
// Sampled on phase-two pulse only
assign service = i_phase_two_pulse & global_irq_enable & ~stack_full
   & (req_ext | req_tmr);
assign take_ext = service & req_ext;
assign take_tmr = service & ~req_ext;
assign interrupt_control = {2'b00, timer_irq_pending, ext_irq_pending,
   1'b0, timer_irq_enable, ext_irq_enable, global_irq_enable};
assign wr_go = (aw_held | i_awvalid) & (w_held | i_wvalid) & ~o_bvalid;
assign wr_addr = aw_held ? aw_addr : i_awaddr;
assign wr_lane0 = w_held ? w_strb[0] : i_wstrb[0];
assign ctrl_wr = wr_go & wr_lane0
   & (wr_addr == irq_unit_pkg::AXI_CTRL_ADDR);
assign stat_clr = wr_go & wr_lane0
   & (wr_addr == irq_unit_pkg::AXI_STAT_ADDR);
assign wr_byte = w_held ? w_data[7:0] : i_wdata[7:0];

////////////////////////////////////////////////////////////////////////////////
// Pin edge detection
always_ff @(posedge i_clk or negedge i_arst_n)
begin
   if (!i_arst_n)
      ext_pin_q <= 1'b1;
   else
      ext_pin_q <= i_ext_irq_n;
end

////////////////////////////////////////////////////////////////////////////////
// Enables
always_ff @(posedge i_clk or negedge i_arst_n)
begin
   if (!i_arst_n)
   begin
      global_irq_enable <= irq_unit_pkg::CTRL_RESET[irq_unit_pkg::GIE_BIT];
      ext_irq_enable <= irq_unit_pkg::CTRL_RESET[irq_unit_pkg::EIE_BIT];
      timer_irq_enable <= irq_unit_pkg::CTRL_RESET[irq_unit_pkg::TIE_BIT];
   end
   else
   begin
      if (ctrl_wr)
      begin
         ext_irq_enable <= wr_byte[irq_unit_pkg::EIE_BIT];
         timer_irq_enable <= wr_byte[irq_unit_pkg::TIE_BIT];
      end
      if (service)
         global_irq_enable <= 1'b0;
      else if (i_return_from_irq_op)
         global_irq_enable <= 1'b1;
      else if (ctrl_wr)
         global_irq_enable <= wr_byte[irq_unit_pkg::GIE_BIT];
   end
end

////////////////////////////////////////////////////////////////////////////////
// Pending flags: hardware set beats software clear
always_ff @(posedge i_clk or negedge i_arst_n)
begin
   if (!i_arst_n)
   begin
      ext_irq_pending <= irq_unit_pkg::CTRL_RESET[irq_unit_pkg::EPEND_BIT];
      timer_irq_pending <= irq_unit_pkg::CTRL_RESET[irq_unit_pkg::TPEND_BIT];
   end
   else
   begin
      if (ext_fall)
         ext_irq_pending <= 1'b1;
      else if (take_ext)
         ext_irq_pending <= 1'b0;
      else if (ctrl_wr)
         ext_irq_pending <= wr_byte[irq_unit_pkg::EPEND_BIT];
      if (i_timer_overflow)
         timer_irq_pending <= 1'b1;
      else if (take_tmr)
         timer_irq_pending <= 1'b0;
      else if (ctrl_wr)
         timer_irq_pending <= wr_byte[irq_unit_pkg::TPEND_BIT];
   end
end

////////////////////////////////////////////////////////////////////////////////
// Return stack level
always_ff @(posedge i_clk or negedge i_arst_n)
begin
   if (!i_arst_n)
      stack_level_index <= 2'h0;
   else if (service || (i_call_op && !stack_full))
      stack_level_index <= stack_level_index + 2'h1;
   else if ((i_return_from_irq_op || i_plain_return_op)
      && stack_level_index != 2'h0)
      stack_level_index <= stack_level_index - 2'h1;
end

////////////////////////////////////////////////////////////////////////////////
// Acknowledge outputs
always_ff @(posedge i_clk or negedge i_arst_n)
begin
   if (!i_arst_n)
   begin
      o_ack <= '0;
      o_push_pc <= 1'b0;
   end
   else
   begin
      o_ack.valid <= service;
      o_push_pc <= service;
      if (take_ext)
         o_ack.vector <= irq_unit_pkg::EXT_VECTOR;
      else if (take_tmr)
         o_ack.vector <= irq_unit_pkg::TMR_VECTOR;
   end
end

// Wake from power-down on a source event whose flag is not already pending
always_ff @(posedge i_clk or negedge i_arst_n)
begin
   if (!i_arst_n)
      o_wake <= 1'b0;
   else
      o_wake <= i_halted & ((ext_fall & ~ext_irq_pending)
         | (i_timer_overflow & ~timer_irq_pending));
end

////////////////////////////////////////////////////////////////////////////////
// Event status and mask: bit 0 external, bit 1 timer
always_ff @(posedge i_clk or negedge i_arst_n)
begin
   if (!i_arst_n)
   begin
      evt_status <= 2'h0;
      evt_mask <= 2'h0;
   end
   else
   begin
      evt_status <= {i_timer_overflow, ext_fall}
         | (evt_status & ~(stat_clr ? wr_byte[1:0] : 2'h0));
      if (wr_go && wr_lane0 && wr_addr == irq_unit_pkg::AXI_MASK_ADDR)
         evt_mask <= wr_byte[1:0];
   end
end

assign o_irq = |(evt_status & evt_mask);

////////////////////////////////////////////////////////////////////////////////
// AXI4-Lite write channel
assign o_awready = ~aw_held & ~o_bvalid;
assign o_wready = ~w_held & ~o_bvalid;

always_ff @(posedge i_clk or negedge i_arst_n)
begin
   if (!i_arst_n)
   begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 6'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      o_bvalid <= 1'b0;
      o_bresp <= irq_unit_pkg::AXI_OKAY;
   end
   else
   begin
      if (wr_go)
      begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         o_bvalid <= 1'b1;
         case (aw_held ? aw_addr : i_awaddr)
            irq_unit_pkg::AXI_CTRL_ADDR, irq_unit_pkg::AXI_STAT_ADDR,
            irq_unit_pkg::AXI_MASK_ADDR, irq_unit_pkg::AXI_STACK_ADDR:
               o_bresp <= irq_unit_pkg::AXI_OKAY;
            default:
               o_bresp <= irq_unit_pkg::AXI_SLVERR;
         endcase
      end
      else
      begin
         if (i_awvalid && o_awready)
         begin
            aw_held <= 1'b1;
            aw_addr <= i_awaddr;
         end
         if (i_wvalid && o_wready)
         begin
            w_held <= 1'b1;
            w_data <= i_wdata;
            w_strb <= i_wstrb;
         end
      end
      if (o_bvalid && i_bready)
         o_bvalid <= 1'b0;
   end
end

////////////////////////////////////////////////////////////////////////////////
// AXI4-Lite read channel
assign o_arready = ~o_rvalid;

always_ff @(posedge i_clk or negedge i_arst_n)
begin
   if (!i_arst_n)
   begin
      o_rvalid <= 1'b0;
      o_rdata <= 32'h00000000;
      o_rresp <= irq_unit_pkg::AXI_OKAY;
   end
   else if (i_arvalid && o_arready)
   begin
      o_rvalid <= 1'b1;
      o_rresp <= irq_unit_pkg::AXI_OKAY;
      case (i_araddr)
         irq_unit_pkg::AXI_CTRL_ADDR:
            o_rdata <= {24'h000000, interrupt_control};
         irq_unit_pkg::AXI_STAT_ADDR:
            o_rdata <= {30'h00000000, evt_status};
         irq_unit_pkg::AXI_MASK_ADDR:
            o_rdata <= {30'h00000000, evt_mask};
         irq_unit_pkg::AXI_STACK_ADDR:
            o_rdata <= {30'h00000000, stack_level_index};
         default:
         begin
            o_rdata <= 32'h00000000;
            o_rresp <= irq_unit_pkg::AXI_SLVERR;
         end
      endcase
   end
   else if (o_rvalid && i_rready)
      o_rvalid <= 1'b0;
end

////////////////////////////////////////////////////////////////////////////////
// Checks
chk_gie_cleared: assert property (@(posedge i_clk) disable iff (!i_arst_n)
   service |=> !global_irq_enable)
   else $error("global enable not cleared on service");
chk_pend_held: assert property (@(posedge i_clk) disable iff (!i_arst_n)
   (ext_fall && !global_irq_enable) |=> ext_irq_pending)
   else $error("pending lost while disabled");
chk_nest_ok: assert property (@(posedge i_clk) disable iff (!i_arst_n)
   (i_phase_two_pulse && global_irq_enable && req_ext && !stack_full)
   |=> o_ack.valid)
   else $error("enabled request not acknowledged");
chk_stack_block: assert property (@(posedge i_clk) disable iff (!i_arst_n)
   stack_full |=> !o_ack.valid)
   else $error("acknowledge while stack full");
chk_push_pair: assert property (@(posedge i_clk) disable iff (!i_arst_n)
   (o_ack.valid == o_push_pc)
   && (!o_push_pc || stack_level_index != 2'h0))
   else $error("push and acknowledge or stack level differ");
chk_ext_edge: assert property (@(posedge i_clk) disable iff (!i_arst_n)
   ($past(i_ext_irq_n) && !i_ext_irq_n) |=> interrupt_control[4])
   else $error("falling edge did not set flag");
chk_ext_vector: assert property (@(posedge i_clk) disable iff (!i_arst_n)
   (take_ext && !ext_fall) |=> o_ack.vector == 10'h004
   && !ext_irq_pending)
   else $error("external vector wrong");
chk_tmr_set: assert property (@(posedge i_clk) disable iff (!i_arst_n)
   i_timer_overflow |=> interrupt_control[5])
   else $error("overflow did not set flag");
chk_tmr_vector: assert property (@(posedge i_clk) disable iff (!i_arst_n)
   (take_tmr && !i_timer_overflow) |=> o_ack.vector == 10'h008
   && !timer_irq_pending)
   else $error("timer vector wrong");
chk_return_from_irq_op_sets: assert property (@(posedge i_clk) disable iff (!i_arst_n)
   (i_return_from_irq_op && !service) |=> global_irq_enable)
   else $error("return from interrupt left enable clear");
chk_pulse_only: assert property (@(posedge i_clk) disable iff (!i_arst_n)
   !$past(i_phase_two_pulse) |-> !o_ack.valid)
   else $error("service outside phase-two pulse");
chk_prio: assert property (@(posedge i_clk) disable iff (!i_arst_n)
   (service && req_ext && req_tmr) |=> o_ack.vector == 10'h004)
   else $error("priority wrong");
chk_zero_bits: assert property (@(posedge i_clk) disable iff (!i_arst_n)
   (i_arvalid && o_arready && i_araddr == irq_unit_pkg::AXI_CTRL_ADDR)
   |=> (o_rdata[31:6] == 26'h0000000 && o_rdata[3] == 1'b0))
   else $error("unused bits not zero");

endmodule

//--- tb/core_seq.sv
// Core sequencer model: phase-two pulses, call/return ops, stack level
`timescale 1ns/1ps
module core_seq
(
   input wire logic i_clk,
   input wire logic i_arst_n,
   input wire logic i_push_pc,
   input wire logic [2:0] i_cmd,
   output logic o_pulse,
   output logic [2:0] o_op,
   output logic [1:0] o_level
);
   logic [1:0] cnt;
   ////////////////////////////////////////////////////////////////////////
   // Phase-two pulse every fourth cycle
   always_ff @(posedge i_clk or negedge i_arst_n)
      if (!i_arst_n)
         cnt <= 2'h0;
      else
         cnt <= cnt + 2'h1;
   assign o_pulse = (cnt == 2'h3);
   ////////////////////////////////////////////////////////////////////////
   // Op pulses: bit 0 call, bit 1 plain return, bit 2 return-from-irq
   always_ff @(posedge i_clk or negedge i_arst_n)
      if (!i_arst_n)
         o_op <= 3'h0;
      else
         o_op <= i_cmd;
   ////////////////////////////////////////////////////////////////////////
   // Two-level stack holds the program counter only
   always_ff @(posedge i_clk or negedge i_arst_n)
      if (!i_arst_n)
         o_level <= 2'h0;
      else if ((o_op[0] || i_push_pc) && o_level != 2'h2)
         o_level <= o_level + 2'h1;
      else if ((o_op[1] || o_op[2]) && o_level != 2'h0)
         o_level <= o_level - 2'h1;
endmodule

//--- tb/testbench.sv
// Self-checking bench for the two-source interrupt unit
`timescale 1ns/1ps
module testbench;
   logic clk, arst_n, ext_n, tmr, halted, awvalid, wvalid, bready;
   logic arvalid, rready, pulse, awready, wready, bvalid, arready, rvalid;
   logic irq, wake, push, prev_p;
   logic [2:0] cmd, op;
   logic [1:0] level, bresp, rresp, resp;
   logic [5:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rd, v;
   irq_unit_pkg::ack_t ack;
   logic [9:0] acks[$];
   int n_fail, checked, n_wake, seed;
   irq_unit i_dut
   (
      .i_clk(clk), .i_arst_n(arst_n), .i_ext_irq_n(ext_n),
      .i_timer_overflow(tmr), .i_phase_two_pulse(pulse),
      .i_return_from_irq_op(op[2]), .i_plain_return_op(op[1]),
      .i_call_op(op[0]), .i_halted(halted), .i_awaddr(awaddr),
      .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
      .i_wstrb(4'hf), .i_wvalid(wvalid), .o_wready(wready),
      .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
      .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
      .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
      .i_rready(rready), .o_ack(ack), .o_push_pc(push), .o_wake(wake),
      .o_irq(irq)
   );
   core_seq i_core
   (
      .i_clk(clk), .i_arst_n(arst_n), .i_push_pc(push), .i_cmd(cmd),
      .o_pulse(pulse), .o_op(op), .o_level(level)
   );
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic hang;
      n_fail++;
      $display("[FAIL] %0t wait timed out", $time);
      wrap_up();
   endtask
   task automatic axw(input logic [5:0] a, input logic [31:0] d);
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (int n = 0; n < 40; n++)
      begin
         @(posedge clk);
         if (awvalid && awready)
            awvalid <= 1'b0;
         if (wvalid && wready)
            wvalid <= 1'b0;
         if (bvalid && bready)
         begin
            resp = bresp;
            bready <= 1'b0;
            return;
         end
      end
      hang();
   endtask
   task automatic axr(input logic [5:0] a);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (int n = 0; n < 40; n++)
      begin
         @(posedge clk);
         if (arvalid && arready)
            arvalid <= 1'b0;
         if (rvalid && rready)
         begin
            rd = rdata;
            resp = rresp;
            rready <= 1'b0;
            return;
         end
      end
      hang();
   endtask
   task automatic ctrl(input logic [7:0] e);
      axr(irq_unit_pkg::AXI_CTRL_ADDR);
      chk(rd, {24'h0, e});
   endtask
   task automatic pin_fall;
      @(posedge clk);
      ext_n <= 1'b0;
      repeat (3) @(posedge clk);
      ext_n <= 1'b1;
   endtask
   task automatic tick;
      @(posedge clk);
      tmr <= 1'b1;
      @(posedge clk);
      tmr <= 1'b0;
   endtask
   task automatic core(input logic [2:0] c);
      @(posedge clk);
      cmd <= c;
      @(posedge clk);
      cmd <= 3'h0;
   endtask
   task automatic got(input int k, input logic [9:0] e);
      for (int n = 0; n < 40 && acks.size() < k; n++)
         @(posedge clk);
      if (acks.size() < k)
         hang();
      chk(32'(acks[k - 1]), 32'(e));
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Ack monitor
   always @(posedge clk)
   begin
      if (push === 1'b1 || ack.valid === 1'b1)
      begin
         chk(32'(push), 32'(ack.valid));
         chk(32'(prev_p), 32'h1);
         acks.push_back(ack.vector);
      end
      if (wake === 1'b1)
         n_wake++;
      prev_p <= pulse;
   end
   initial
   begin
      {ext_n, tmr, halted, cmd, awvalid, wvalid, bready} = 9'h100;
      {arvalid, rready, awaddr, araddr, wdata} = 0;
      {n_fail, checked, n_wake} = 0;
      seed = 32'hcffc9b6d;
      arst_n = 1'b0;
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      ctrl(8'h00);
      axr(6'h00);
      chk(32'(resp), 32'(irq_unit_pkg::AXI_SLVERR));
      axw(6'h00, 32'h0);
      chk(32'(resp), 32'(irq_unit_pkg::AXI_SLVERR));
      for (int i = 0; i < 4; i++)
      begin
         v = $random(seed) & 32'hce;
         axw(irq_unit_pkg::AXI_CTRL_ADDR, v);
         ctrl(v[7:0] & 8'h06);
      end
      axw(irq_unit_pkg::AXI_CTRL_ADDR, 32'h0);
      chk(32'(resp), 32'(irq_unit_pkg::AXI_OKAY));
      $display("test registers done");
      halted <= 1'b1;
      pin_fall();
      tick();
      ctrl(8'h30);
      chk(32'(n_wake), 32'h2);
      halted <= 1'b0;
      axr(irq_unit_pkg::AXI_STAT_ADDR);
      chk(rd, 32'h3);
      axw(irq_unit_pkg::AXI_MASK_ADDR, 32'h2);
      chk(32'(irq), 32'h1);
      axw(irq_unit_pkg::AXI_STAT_ADDR, 32'h2);
      chk(32'(irq), 32'h0);
      $display("test events done");
      core(3'h1);
      axr(irq_unit_pkg::AXI_STACK_ADDR);
      chk(rd, 32'h1);
      core(3'h2);
      axw(irq_unit_pkg::AXI_CTRL_ADDR, 32'h37);
      got(1, irq_unit_pkg::EXT_VECTOR);
      ctrl(8'h26);
      core(3'h2);
      repeat (8) @(posedge clk);
      chk(32'(acks.size()), 32'h1);
      core(3'h4);
      got(2, irq_unit_pkg::TMR_VECTOR);
      ctrl(8'h06);
      axw(irq_unit_pkg::AXI_CTRL_ADDR, 32'h07);
      pin_fall();
      got(3, irq_unit_pkg::EXT_VECTOR);
      axr(irq_unit_pkg::AXI_STACK_ADDR);
      chk(rd, 32'h2);
      chk(32'(level), 32'h2);
      axw(irq_unit_pkg::AXI_CTRL_ADDR, 32'h07);
      tick();
      repeat (12) @(posedge clk);
      chk(32'(acks.size()), 32'h3);
      ctrl(8'h27);
      core(3'h2);
      got(4, irq_unit_pkg::TMR_VECTOR);
      $display("test service done");
      chk(32'(n_wake), 32'h2);
      wrap_up();
   end
endmodule
